// [ret_rotate_subborrow_exec_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module ret_rotate_subborrow_exec_tb_top;
   typedef struct {logic [7:0] acc; logic [4:0] fl; logic [10:0] pc; logic [3:0] lvl; logic [15:0] wr;} rrsx_note_s;
   logic clk = 0, rst_n = 0, issue = 0, dest = 0, push = 0, t, busy, reg_we, pc_load, zero_flag;
   logic digit_carry_flag, carry_flag, m_c = 0, m_z = 0, m_dc = 0;
   logic [2:0] op = 0, o;
   logic [6:0] reg_addr = 0, reg_waddr;
   logic [7:0] immediate = 0, reg_rdata = 0, reg_wdata, accumulator, m_acc = 0;
   logic [10:0] pc_push = 0, pc, m_pc = 0;
   logic [10:0] stk [8];
   logic [3:0] stack_level;
   int seed = 31, lvl = 0, err_total = 0, check_count = 0;
   rrsx_note_s q[$], n;
   rrsx_exec rrsx_exec_i (.clk(clk), .rst_n(rst_n), .issue(issue), .op(op), .reg_addr(reg_addr), .dest(dest),
      .immediate(immediate), .reg_rdata(reg_rdata), .push(push), .pc_push(pc_push), .busy(busy),
      .reg_we(reg_we), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .accumulator(accumulator), .pc(pc),
      .pc_load(pc_load), .stack_level(stack_level), .zero_flag(zero_flag),
      .digit_carry_flag(digit_carry_flag), .carry_flag(carry_flag));
   // ---------------------------------------------
   // clock, watchdog and shared tasks
   // ---------------------------------------------
   initial begin
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (3000) @(posedge clk);
      err_total++; // a hung run counts as a mismatch
      results();
   end
   task cmp(string nm, logic [15:0] e, logic [15:0] g);
      check_count++;
      if (e !== g) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp
   task results();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results
   // drive one instruction and note what the core must show one cycle later
   task exec(logic [2:0] o, logic d, logic [7:0] imm);
      logic [7:0] a, r, rd;
      logic [6:0] ad;
      logic [8:0] s;
      logic [4:0] h;
      rd = 8'($random(seed));
      ad = 7'($random(seed));
      r = 8'h00;
      n.wr = 16'h0000;
      case (o)
         3'(rrsx_pkg::RRSX_OP_RET): begin
            lvl--;
            m_pc = stk[lvl];
         end
         3'(rrsx_pkg::RRSX_OP_RRR): begin
            r = {m_c, rd[7:1]};
            m_c = rd[0];
         end
         default: begin
            a = (o == 3'(rrsx_pkg::RRSX_OP_SBI)) ? imm : rd;
            s = {1'b0, a} + {1'b0, ~m_acc} + 9'(m_c);
            h = {1'b0, a[3:0]} + {1'b0, ~m_acc[3:0]} + 5'(m_c);
            r = s[7:0];
            m_c = s[8];
            m_dc = h[4];
            m_z = (r == 8'h00);
         end
      endcase
      if (o != 3'(rrsx_pkg::RRSX_OP_RET)) begin
         if (d && o != 3'(rrsx_pkg::RRSX_OP_SBI)) n.wr = {1'b1, ad, r};
         else m_acc = r;
      end
      n.acc = m_acc;
      n.fl = {o == 3'(rrsx_pkg::RRSX_OP_RET), o == 3'(rrsx_pkg::RRSX_OP_RET), m_z, m_dc, m_c};
      n.pc = m_pc;
      n.lvl = 4'(lvl);
      q.push_back(n);
      issue <= 1'b1;
      op <= o;
      dest <= d;
      reg_addr <= ad;
      immediate <= imm;
      reg_rdata <= rd;
      @(posedge clk);
      if (o == 3'(rrsx_pkg::RRSX_OP_RET)) begin
         op <= 3'(rrsx_pkg::RRSX_OP_SBI); // offered while busy, must be ignored
         @(posedge clk);
      end
   endtask : exec
   // ---------------------------------------------
   // stimulus
   // ---------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      cmp("reset", 16'h0000, {accumulator, stack_level, zero_flag, digit_carry_flag, carry_flag, busy});
      @(posedge clk);
      for (int i = 0; i < 9; i++) begin
         push <= 1'b1; // ninth push meets a full stack
         if (lvl < rrsx_pkg::STACK_DEPTH) begin
            stk[lvl] = 11'($random(seed));
            pc_push <= stk[lvl];
            lvl++;
         end else begin
            pc_push <= 11'($random(seed));
         end
         @(posedge clk);
      end
      push <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 60; i++) begin
         o = 3'(2 + (($random(seed) & 32'h7fffffff) % 3));
         if (i % 6 == 5 && lvl > 0) exec(3'(rrsx_pkg::RRSX_OP_RET), 1'b0, 8'h00);
         else if (i % 7 == 3) exec(3'(rrsx_pkg::RRSX_OP_SBI), 1'b0, m_acc + 8'h01 - 8'(m_c)); // zero result
         else exec(o, 1'($random(seed)), 8'($random(seed)));
      end
      issue <= 1'b0;
      for (int k = 0; k < 20 && q.size() > 0; k++) @(posedge clk);
      if (q.size() > 0) err_total++;
      results();
   end
   // ---------------------------------------------
   // monitor: each taken instruction shows its result one cycle on
   // ---------------------------------------------
   initial begin
      forever begin
         @(posedge clk);
         t = issue && !busy && rst_n;
         @(negedge clk);
         if (t && q.size() > 0) begin
            n = q.pop_front();
            cmp("accumulator", 16'(n.acc), 16'(accumulator));
            cmp("flags", 16'(n.fl), 16'({pc_load, busy, zero_flag, digit_carry_flag, carry_flag}));
            cmp("pc", 16'(n.pc), 16'(pc));
            cmp("level", 16'(n.lvl), 16'(stack_level));
            cmp("write", n.wr, reg_we ? {1'b1, reg_waddr, reg_wdata} : 16'h0000);
         end
      end
   end
endmodule : ret_rotate_subborrow_exec_tb_top
`default_nettype wire

// [rrsx_exec.sv]
// Contract
// - return loads pc from stack top, pops one level, keeps flags, two cycles
// - rotate right: old carry to bit 7, bits 7..1 to 6..0, bit 0 to carry
// - register forms: dest 0 writes accumulator, dest 1 writes register back
// - rotate takes register address 0..127, changes only carry, one cycle
// - register subtract: reg + ~acc + carry, updates zero, digit carry, carry
// - immediate subtract: imm + ~acc + carry into accumulator, flags, one cycle
`timescale 1ns/1ns
`default_nettype none
module rrsx_exec (
   input  wire logic       clk,           // core clock, 125 MHz
   input  wire logic       rst_n,         // async reset, active low
   input  wire logic       issue,         // one-cycle pulse: decoded instruction
   input  wire logic [2:0] op,            // rrsx_op_e selector
   input  wire logic [6:0] reg_addr,      // data register address
   input  wire logic       dest,          // 0 accumulator, 1 register
   input  wire logic [7:0] immediate,     // 8-bit immediate operand
   input  wire logic [7:0] reg_rdata,     // data register read value
   input  wire logic       push,          // call pushes pc_push
   input  wire logic [10:0] pc_push,      // return address to push
   output logic            busy,          // stall fetch while second return cycle
   output logic            reg_we,        // data register write strobe
   output logic      [6:0] reg_waddr,     // write address
   output logic      [7:0] reg_wdata,     // write data
   output logic      [7:0] accumulator,   // accumulator
   output logic      [10:0] pc,           // program counter
   output logic            pc_load,       // pulse when pc loaded from stack
   output logic      [3:0] stack_level,   // entries on return stack
   output logic            zero_flag,     // Z
   output logic            digit_carry_flag, // DC
   output logic            carry_flag     // C
);
   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {RRSX_IDLE, RRSX_RET2} rrsx_state_e;
   rrsx_state_e state;

   wire is_ret = issue && (op == 3'(rrsx_pkg::RRSX_OP_RET));
   wire is_rrr = issue && (op == 3'(rrsx_pkg::RRSX_OP_RRR));
   wire is_sbr = issue && (op == 3'(rrsx_pkg::RRSX_OP_SBR));
   wire is_sbi = issue && (op == 3'(rrsx_pkg::RRSX_OP_SBI));
   wire accept = (state == RRSX_IDLE);

   // ----------------------------------------------------------------
   // datapath
   // ----------------------------------------------------------------
   logic [7:0] sub_res;
   logic       sub_c;
   logic       sub_dc;
   logic       sub_z;
   wire  [7:0] sub_a   = is_sbi ? immediate : reg_rdata;

   rrsx_sub_borrow u_sub (
      .minuend    (sub_a),
      .subtrahend (accumulator),
      .carry_in   (carry_flag),
      .result     (sub_res),
      .carry_out  (sub_c),
      .digit_out  (sub_dc),
      .zero_out   (sub_z)
   );

   // rotate right through carry
   wire [7:0] rot_res = {carry_flag, reg_rdata[rrsx_pkg::MSB:1]};
   wire       rot_c   = reg_rdata[0];

   wire       do_rrr  = accept && is_rrr;
   wire       do_sbr  = accept && is_sbr;
   wire       do_sbi  = accept && is_sbi;
   wire       do_ret  = accept && is_ret;
   wire       reg_op  = do_rrr || do_sbr;
   wire [7:0] reg_res = do_rrr ? rot_res : sub_res;
   wire       to_reg  = reg_op && dest;
   wire       to_acc  = (reg_op && !dest) || do_sbi;
   wire       sub_any = do_sbr || do_sbi;

   // ----------------------------------------------------------------
   // return stack storage
   // ----------------------------------------------------------------
   logic [10:0] stack_mem [rrsx_pkg::STACK_DEPTH];
   wire  [2:0]  top_idx  = 3'(stack_level - 4'h1);
   wire  [2:0]  push_idx = stack_level[2:0];
   wire         can_push = push && accept && !is_ret && (stack_level != rrsx_pkg::SP_FULL);

   // push writes; overflow push is dropped, a limitation of the fixed depth
   always_ff @(posedge clk) begin
      if (can_push) begin
         stack_mem[push_idx] <= pc_push;
      end
   end

   // ----------------------------------------------------------------
   // sequencing: return spends a second cycle, fetch stalls via busy
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= RRSX_IDLE;
      end else if (do_ret) begin
         state <= RRSX_RET2;
      end else begin
         state <= RRSX_IDLE;
      end
   end
   assign busy = (state == RRSX_RET2);

   // pc load from stack top and pop one level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc          <= rrsx_pkg::PC_RESET;
         pc_load     <= 1'b0;
         stack_level <= rrsx_pkg::SP_RESET;
      end else begin
         pc_load <= do_ret;
         if (do_ret) begin
            pc          <= stack_mem[top_idx];
            stack_level <= (stack_level == rrsx_pkg::SP_RESET) ? stack_level : stack_level - 4'h1;
         end else if (can_push) begin
            stack_level <= stack_level + 4'h1;
         end
      end
   end

   // accumulator and register write-back
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         accumulator <= rrsx_pkg::ACC_RESET;
         reg_we      <= 1'b0;
         reg_waddr   <= 7'h00;
         reg_wdata   <= rrsx_pkg::ZERO_BYTE;
      end else begin
         reg_we <= to_reg;
         if (to_reg) begin
            reg_waddr <= reg_addr;
            reg_wdata <= reg_res;
         end
         if (to_acc) begin
            accumulator <= do_rrr ? rot_res : sub_res;
         end
      end
   end

   // flags: return leaves all, rotate touches only carry
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         zero_flag        <= 1'b0;
         digit_carry_flag <= 1'b0;
         carry_flag       <= 1'b0;
      end else if (do_rrr) begin
         carry_flag <= rot_c;
      end else if (sub_any) begin
         zero_flag        <= sub_z;
         digit_carry_flag <= sub_dc;
         carry_flag       <= sub_c;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_ret_issue;
      do_ret;
   endsequence
   sequence s_ret_done;
      busy ##1 !busy;
   endsequence

   // a return must spend exactly one stall cycle, then accept again
   a_ret_two_cycles: assert property (
      @(posedge clk) disable iff (!rst_n) s_ret_issue |=> s_ret_done)
      else $error("return not two cycles");
   a_ret_flags_kept: assert property (
      @(posedge clk) disable iff (!rst_n) do_ret |=> $stable({zero_flag, digit_carry_flag, carry_flag}))
      else $error("return changed flags");
   a_ret_pops: assert property (
      @(posedge clk) disable iff (!rst_n) (do_ret && stack_level != 4'h0) |=> stack_level == $past(stack_level) - 4'h1)
      else $error("return did not pop");
   a_ret_pc_load: assert property (
      @(posedge clk) disable iff (!rst_n) do_ret |=> pc_load && !reg_we && $stable(accumulator))
      else $error("return load wrong");
   // while stalled no instruction may touch the datapath
   a_busy_ignores: assert property (
      @(posedge clk) disable iff (!rst_n) busy |=> !reg_we && !pc_load && $stable(accumulator))
      else $error("issue taken while busy");
   a_rot_carry: assert property (
      @(posedge clk) disable iff (!rst_n)
      do_rrr |=> carry_flag == $past(reg_rdata[0]) && $stable(zero_flag) && $stable(digit_carry_flag))
      else $error("rotate carry wrong");
   a_rot_value: assert property (
      @(posedge clk) disable iff (!rst_n) (do_rrr && dest) |=> reg_wdata == {$past(carry_flag), $past(reg_rdata[7:1])})
      else $error("rotate result wrong");
   a_rot_acc_value: assert property (
      @(posedge clk) disable iff (!rst_n)
      (do_rrr && !dest) |=> accumulator == {$past(carry_flag), $past(reg_rdata[7:1])})
      else $error("rotate to accumulator wrong");
   a_dest_reg: assert property (
      @(posedge clk) disable iff (!rst_n) (reg_op && dest) |=> reg_we && $stable(accumulator))
      else $error("register dest wrong");
   a_dest_acc: assert property (
      @(posedge clk) disable iff (!rst_n) (reg_op && !dest) |=> !reg_we)
      else $error("acc dest wrote register");
   a_sbi_value: assert property (
      @(posedge clk) disable iff (!rst_n)
      do_sbi |=> accumulator == 8'($past(immediate) + ~$past(accumulator) + 8'($past(carry_flag))))
      else $error("immediate subtract wrong");
   a_sbr_value: assert property (
      @(posedge clk) disable iff (!rst_n)
      (do_sbr && dest) |=> reg_wdata == 8'($past(reg_rdata) + ~$past(accumulator) + 8'($past(carry_flag))))
      else $error("register subtract wrong");
   a_sbr_zero: assert property (
      @(posedge clk) disable iff (!rst_n) (do_sbr && dest) |=> zero_flag == (reg_wdata == 8'h00))
      else $error("zero flag wrong");
   // carry out of the full sum is the inverted borrow out of bit 7
   a_sub_carry: assert property (
      @(posedge clk) disable iff (!rst_n)
      sub_any |=> carry_flag == ({1'b0, $past(sub_a)} + {1'b0, ~$past(accumulator)}
                                 + {8'h00, $past(carry_flag)} > 9'h0ff))
      else $error("borrow flag wrong");
   // digit carry is the inverted borrow out of bit 3
   a_sub_digit: assert property (
      @(posedge clk) disable iff (!rst_n)
      sub_any |=> digit_carry_flag == ({1'b0, $past(sub_a[3:0])} + {1'b0, ~$past(accumulator[3:0])}
                                       + {4'h0, $past(carry_flag)} > 5'h0f))
      else $error("digit borrow flag wrong");
endmodule : rrsx_exec
`default_nettype wire

// [rrsx_pkg.sv]
`default_nettype none
package rrsx_pkg;
   // instruction selector codes from decode
   typedef enum logic [2:0] {
      RRSX_OP_NONE,
      RRSX_OP_RET,
      RRSX_OP_RRR,
      RRSX_OP_SBR,
      RRSX_OP_SBI
   } rrsx_op_e;

   localparam int          DATA_W       = 8;
   localparam int          ADDR_W       = 7;
   localparam int          PC_W         = 11;
   localparam int          STACK_DEPTH  = 8;
   localparam int          SP_W         = 4;
   localparam int          MSB          = 7;
   localparam int          NIB_W        = 4;
   localparam int          RET_CYCLES   = 2;
   localparam logic [7:0]  ACC_RESET    = 8'h00;
   localparam logic [10:0] PC_RESET     = 11'h000;
   localparam logic [3:0]  SP_RESET     = 4'h0;
   localparam logic [3:0]  SP_FULL      = 4'h8;
   localparam logic [7:0]  ZERO_BYTE    = 8'h00;
endpackage : rrsx_pkg
`default_nettype wire

// [rrsx_sub_borrow.sv]
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// subtract with borrow: a + ~b + cin, flags as no-borrow carries
// ----------------------------------------------------------------
module rrsx_sub_borrow (
   input  wire logic [7:0] minuend,     // register or immediate
   input  wire logic [7:0] subtrahend,  // accumulator
   input  wire logic       carry_in,    // carry flag, 1 = no borrow pending
   output logic      [7:0] result,      // 8-bit difference
   output logic            carry_out,   // 1 = no borrow out of bit 7
   output logic            digit_out,   // 1 = no borrow out of bit 3
   output logic            zero_out     // result equals zero
);
   logic [8:0] full_sum;
   logic [4:0] low_sum;

   // full and low-nibble sums; the carry out of each is the inverted borrow
   assign full_sum  = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, carry_in};
   assign low_sum   = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
   assign result    = full_sum[7:0];
   assign carry_out = full_sum[8];
   assign digit_out = low_sum[4];
   assign zero_out  = (full_sum[7:0] == rrsx_pkg::ZERO_BYTE);
endmodule : rrsx_sub_borrow
`default_nettype wire
